// [rtl/abtt_burst_timing.sv]
// Operation
// - Bits 5..0 of the burst track time register hold the field that sets the delay between burst conversions.
// - The delay between conversions lasts (64 minus the field) units of 50 ns.
// - With track mode select high, three extra SAR clocks of tracking precede every conversion.
// - The first conversion of a burst gets no programmed delay, only later ones do.
// - Bits 7 and 6 read as zero, bit 7 must be written zero and writes to bit 6 are ignored.
// - A conversion takes 11 clocks at 8 bits, 13 at 10 bits, and 52 as four 13-clock parts at 12 bits.
`timescale 1ns/1ns
`default_nettype none
`include "abtt_cfg.svh"

module abtt_burst_timing #(
   parameter int RPT_W = 8
) (
   input  wire logic             clk,               // SAR clock, 50 MHz
   input  wire logic             resetn,            // System reset, active low
   input  wire logic [7:0]       sfr_addr,          // Special function register address
   input  wire logic             sfr_wr,            // Register write strobe
   input  wire logic             sfr_rd,            // Register read strobe
   input  wire logic [7:0]       sfr_wdata,         // Register write data
   output logic      [7:0]       sfr_rdata,         // Register read data, one cycle after the strobe
   input  wire logic             burst_start,       // Pulse that starts a burst
   input  wire logic [RPT_W-1:0] repeat_count,      // Conversions per burst, zero counts as one
   input  wire logic             track_mode_select, // Adds extra track clocks before each conversion
   input  wire logic [1:0]       resolution,        // 0: 8 bit, 1: 10 bit, 2: 12 bit
   output logic                  tracking,          // Input is being tracked
   output logic                  converting,        // Conversion in progress
   output logic                  conv_done,         // One-cycle pulse per finished conversion
   output logic                  burst_busy         // Burst in progress
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   localparam logic [11:0] CLK_NS   = 12'(`ABTT_CLK_PERIOD_NS);
   localparam logic [5:0]  EXTRA_N  = 6'(`ABTT_EXTRA_TRACK_CLKS);
   localparam logic [1:0]  LAST_SUB = 2'(`ABTT_SUBCONV_12BIT - 1);

   function automatic logic [5:0] conv_clks(input logic [1:0] res);
      conv_clks = (res == `ABTT_RES_8BIT) ? 6'(`ABTT_CONV_CLKS_8BIT) : 6'(`ABTT_CONV_CLKS_10BIT);
   endfunction

   // Target in ns; a least time, so the cycle count rounds up by the compare below.
   function automatic logic [11:0] track_ns(input logic [5:0] fld);
      track_ns = 12'((`ABTT_TRACK_BASE - int'(fld)) * `ABTT_TRACK_UNIT_NS);
   endfunction

   abtt_pkg::abtt_regs_s r_q;
   abtt_pkg::abtt_regs_s r_d;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_d      = r_q;
      r_d.done = 1'b0;

      if (sfr_wr && sfr_addr == `ABTT_BURST_TRACK_TIME_ADDR) begin
         r_d.field = sfr_wdata[`ABTT_FIELD_MSB:`ABTT_FIELD_LSB];
      end
      r_d.rdata = (sfr_rd && sfr_addr == `ABTT_BURST_TRACK_TIME_ADDR) ? {2'h0, r_q.field} : 8'h00;

      case (r_q.st)
         abtt_pkg::ST_IDLE: begin
            if (burst_start) begin
               r_d.busy = 1'b1;
               r_d.left = (repeat_count == '0) ? 8'h00 : 8'(repeat_count - 1'b1);
               r_d.cyc  = 6'h00;
               r_d.sub  = 2'h0;
               if (track_mode_select) begin
                  r_d.st       = abtt_pkg::ST_EXTRA;
                  r_d.tracking = 1'b1;
               end else begin
                  r_d.st         = abtt_pkg::ST_CONV;
                  r_d.converting = 1'b1;
               end
            end
         end
         abtt_pkg::ST_TRACK: begin
            if (r_q.ns + CLK_NS >= track_ns(r_q.field)) begin
               r_d.ns  = 12'h000;
               r_d.cyc = 6'h00;
               if (track_mode_select) begin
                  r_d.st = abtt_pkg::ST_EXTRA;
               end else begin
                  r_d.st         = abtt_pkg::ST_CONV;
                  r_d.tracking   = 1'b0;
                  r_d.converting = 1'b1;
               end
            end else begin
               r_d.ns = r_q.ns + CLK_NS;
            end
         end
         abtt_pkg::ST_EXTRA: begin
            if (r_q.cyc == EXTRA_N - 6'h01) begin
               r_d.cyc        = 6'h00;
               r_d.st         = abtt_pkg::ST_CONV;
               r_d.tracking   = 1'b0;
               r_d.converting = 1'b1;
            end else begin
               r_d.cyc = r_q.cyc + 6'h01;
            end
         end
         abtt_pkg::ST_CONV: begin
            if (r_q.cyc == conv_clks(resolution) - 6'h01) begin
               r_d.cyc = 6'h00;
               if (resolution == `ABTT_RES_12BIT && r_q.sub != LAST_SUB) begin
                  r_d.sub = r_q.sub + 2'h1;
               end else begin
                  r_d.sub        = 2'h0;
                  r_d.done       = 1'b1;
                  r_d.converting = 1'b0;
                  if (r_q.left == 8'h00) begin
                     r_d.st   = abtt_pkg::ST_IDLE;
                     r_d.busy = 1'b0;
                  end else begin
                     r_d.left     = r_q.left - 8'h01;
                     r_d.st       = abtt_pkg::ST_TRACK;
                     r_d.ns       = 12'h000;
                     r_d.tracking = 1'b1;
                  end
               end
            end else begin
               r_d.cyc = r_q.cyc + 6'h01;
            end
         end
         default: begin
            r_d = r_q;
            r_d.st = abtt_pkg::ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_q            <= '0;
         r_q.st         <= abtt_pkg::ST_IDLE;
         r_q.field      <= `ABTT_BURST_TRACK_TIME_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign sfr_rdata  = r_q.rdata;
   assign tracking   = r_q.tracking;
   assign converting = r_q.converting;
   assign conv_done  = r_q.done;
   assign burst_busy = r_q.busy;

endmodule
`default_nettype wire

// [rtl/abtt_cfg.svh]
`ifndef ABTT_CFG_SVH
`define ABTT_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ABTT_BURST_TRACK_TIME_ADDR  8'hbc
`define ABTT_BURST_TRACK_TIME_RESET 6'h1e
`define ABTT_FIELD_MSB              5
`define ABTT_FIELD_LSB              0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ABTT_CLK_PERIOD_NS          20
`define ABTT_TRACK_UNIT_NS          50
`define ABTT_TRACK_BASE             64
`define ABTT_EXTRA_TRACK_CLKS       3
`define ABTT_CONV_CLKS_8BIT         11
`define ABTT_CONV_CLKS_10BIT        13
`define ABTT_SUBCONV_12BIT          4

// ----------------------------------------------------------------
// Resolution codes
// ----------------------------------------------------------------
`define ABTT_RES_8BIT               2'h0
`define ABTT_RES_10BIT              2'h1
`define ABTT_RES_12BIT              2'h2

`endif

// [rtl/abtt_pkg.sv]
package abtt_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_TRACK,
      ST_EXTRA,
      ST_CONV
   } abtt_state_e;

   typedef struct packed {
      abtt_state_e st;
      logic [5:0]  field;
      logic [11:0] ns;
      logic [5:0]  cyc;
      logic [1:0]  sub;
      logic [7:0]  left;
      logic        tracking;
      logic        converting;
      logic        done;
      logic        busy;
      logic [7:0]  rdata;
   } abtt_regs_s;

endpackage

// [verification/abtt_props.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Checker
// ------------------------------------------------
module abtt_props #(
   parameter int RPT_W = 8
) (
   input wire logic             clk,               // clock
   input wire logic             resetn,            // reset
   input wire logic [7:0]       sfr_addr,          // addr
   input wire logic             sfr_wr,            // write
   input wire logic             sfr_rd,            // read
   input wire logic [7:0]       sfr_wdata,         // wdata
   input wire logic [7:0]       sfr_rdata,         // rdata
   input wire logic             burst_start,       // start
   input wire logic [RPT_W-1:0] repeat_count,      // count
   input wire logic             track_mode_select, // mode
   input wire logic [1:0]       resolution,        // res
   input wire logic             tracking,          // track
   input wire logic             converting,        // conv
   input wire logic             conv_done,         // done
   input wire logic             burst_busy         // busy
);
   logic [7:0] cnt_q;
   logic [5:0] fld_q;
   logic       mid_q;
   logic [7:0] exp_t;
   // The tap only counts gaps after a finished conversion, so the first one is judged elsewhere.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 8'h00;
         fld_q <= 6'h1e;
         mid_q <= 1'b0;
      end else begin
         cnt_q <= tracking ? cnt_q + 8'h01 : 8'h00;
         if (sfr_wr && sfr_addr == 8'hbc) fld_q <= sfr_wdata[5:0];
         mid_q <= burst_busy && (mid_q || conv_done);
      end
   end
   assign exp_t = 8'(((7'h40 - 7'(fld_q)) * 5 + 1) / 2) + (track_mode_select ? 8'h03 : 8'h00);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_rd_field: assert property (sfr_wr && sfr_addr == 8'hbc ##1 sfr_rd && !sfr_wr && sfr_addr == 8'hbc
      |=> sfr_rdata == {2'h0, $past(sfr_wdata[5:0], 2)}) else $error("field readback wrong");
   chk_top_zero: assert property (sfr_rdata[7:6] == 2'h0) else $error("upper bits not zero");
   chk_conv_ten: assert property ($rose(converting) && resolution == 2'h1
      |-> converting[*8] ##1 converting[*5] ##1 !converting && conv_done) else $error("10-bit length");
   chk_conv_eight: assert property ($rose(converting) && resolution == 2'h0
      |-> converting[*8] ##1 converting[*3] ##1 !converting && conv_done) else $error("8-bit length");
   chk_first_conv: assert property ($rose(burst_busy)
      |-> converting == !$past(track_mode_select)) else $error("first conversion delayed");
   chk_extra_first: assert property ($rose(burst_busy) && track_mode_select
      |-> tracking[*3] ##1 converting && !tracking) else $error("extra track wrong");
   chk_track_len: assert property ($fell(tracking) && mid_q |-> cnt_q == exp_t)
      else $error("track delay wrong");
   chk_done_pulse: assert property (conv_done |-> $past(converting) && !converting ##1 !conv_done)
      else $error("done pulse wrong");
endmodule
bind abtt_burst_timing abtt_props #(.RPT_W(RPT_W)) u_props (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd,
   .sfr_wdata, .sfr_rdata, .burst_start, .repeat_count, .track_mode_select, .resolution, .tracking,
   .converting, .conv_done, .burst_busy);
`default_nettype wire

// [verification/adc_burst_track_timing_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
// ------------------------------------------------
// Bench
// ------------------------------------------------
module adc_burst_track_timing_tb;
   logic       clk, resetn, sfr_wr, sfr_rd, burst_start, track_mode_select;
   logic       tracking, converting, conv_done, burst_busy;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, repeat_count;
   logic [1:0] resolution;
   int         mismatches, compares, cyc;
   abtt_burst_timing dut (.clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .burst_start,
      .repeat_count, .track_mode_select, .resolution, .tracking, .converting, .conv_done, .burst_busy);
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // One bus cycle; read data is registered, so it is judged just after the taking edge.
   task automatic acc(input logic w, r, input logic [7:0] a, d, e);
      sfr_wr <= w;
      sfr_rd <= r;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      #1;
      `CHK("sfr_rdata", e, sfr_rdata)
   endtask
   task automatic t_regs();
      acc(1'b0, 1'b1, 8'hbc, 8'h00, 8'h1e);
      acc(1'b1, 1'b0, 8'hbc, 8'hff, 8'h00);
      acc(1'b0, 1'b1, 8'hbc, 8'h00, 8'h3f);
      acc(1'b1, 1'b0, 8'h10, 8'h5a, 8'h00);
      acc(1'b0, 1'b1, 8'h10, 8'h00, 8'h00);
      acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_burst(input logic [1:0] r, input logic [7:0] rp, input logic t, input logic [5:0] f);
      int n, d, c, k;
      k = (rp == 8'h00) ? 1 : int'(rp);
      c = (r == 2'h0) ? 11 : ((r == 2'h2) ? 52 : 13);
      acc(1'b1, 1'b0, 8'hbc, {2'h0, f}, 8'h00);
      {resolution, repeat_count, track_mode_select, burst_start} <= {r, rp, t, 1'b1};
      acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      burst_start <= 1'b0;
      n = 0;
      d = 0;
      repeat (400) begin
         if (conv_done === 1'b1) d++;
         if (burst_busy !== 1'b1) break;
         n++;
         @(posedge clk);
         #1;
         burst_start <= (n == 4);
      end
      `CHK("busy cycles", k * c + (k - 1) * (((64 - f) * 5 + 1) / 2) + (t ? 3 * k : 0), n)
      `CHK("conversions", k, d)
      $display("t_burst done");
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      {resetn, sfr_wr, sfr_rd, burst_start, track_mode_select} = '0;
      {sfr_addr, sfr_wdata, repeat_count, resolution} = '0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_regs();
      t_burst(2'h0, 8'h02, 1'b0, 6'h3f);
      t_burst(2'h1, 8'h02, 1'b1, 6'h1e);
      t_burst(2'h2, 8'h01, 1'b0, 6'h3f);
      t_burst(2'h0, 8'h02, 1'b0, 6'h00);
      t_burst(2'h1, 8'h00, 1'b1, 6'h3f);
      tally_and_finish();
   end
endmodule
`default_nettype wire
